// File: logic/evcnt_map.svh
// constants for the event counter block
`ifndef EVCNT_MAP_SVH
`define EVCNT_MAP_SVH
`define CLK_HZ 32'h02FA_F080
`define TICK_1S_NS 32'h3B9A_CA00
`define TICK_200MS_NS 32'h0BEB_C200
`define CLK_PERIOD_NS 32'h0000_0014
`define THRESH_DEFAULT 32'h0000_0064
`define PERIOD_DEFAULT 16'h003C
`define TIME_LIMIT 16'hA8C0
`define EVENT_LIMIT 32'hEE6B_2800
`define TICKS_200MS_PER_S 3'h5
`endif

// File: logic/evcnt_pkg.sv
// types shared by the event counter block
package evcnt_pkg;
  typedef enum logic [1:0] {
    MODE_FREE = 2'b00,
    MODE_TIMED = 2'b01,
    MODE_EVENTS = 2'b10
  } mode_t;
  typedef enum logic [1:0] {
    ITEM_MODE = 2'b00,
    ITEM_THRESH = 2'b01,
    ITEM_PERIOD = 2'b10,
    ITEM_RUN = 2'b11
  } item_t;
  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_RUN = 1'b1
  } run_state_t;
endpackage

// File: logic/event_counter.sv
// event counter with free, timed and events modes and trigger output
//
// Notes on behaviour
// R01: one event per rising edge of event input pin, never falling edges.
// R02: free mode counts time and events until stopped or limited.
// R03: timed mode counts events for preset seconds, then stops.
// R04: events mode times until count reaches threshold, then stops.
// R05: threshold defaults to 100; reset command restores 100.
// R06: threshold editable only in events mode; otherwise ignored.
// R07: period editable only in timed mode, default 60 seconds.
// R08: start/stop command toggles run; starting clears counts.
// R09: outputs published each second while running, held after stop.
// R10: limits are 43200 seconds and 4e9 events.
// R11: exceeding any limit stops counting automatically.
// R12: event limit and threshold checked only every 200 ms.
// R13: enabled trigger output is high exactly while counting.
// R14: select steps mode, threshold, period, start/stop; inc/dec edit.
// R15: ticks come from clock dividers; reset clears all counters.
`timescale 1ns/10ps
`include "evcnt_map.svh"
module event_counter (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic event_input_pin,
  input wire logic sel_next,
  input wire logic inc,
  input wire logic dec,
  input wire logic set_default,
  input wire logic start_stop,
  input wire logic trig_enable,
  output evcnt_pkg::mode_t mode,
  output evcnt_pkg::item_t item,
  output logic [31:0] threshold,
  output logic [15:0] period,
  output logic running,
  output logic [31:0] shown_events,
  output logic [15:0] shown_seconds,
  output logic trigger_out
);
  import evcnt_pkg::*;

  // ----------------------------------------------------------
  // timing ticks
  // ----------------------------------------------------------
  localparam logic [31:0] CYC_200MS = 32'(`TICK_200MS_NS / `CLK_PERIOD_NS);

  logic [31:0] div_ff;
  logic [2:0] sub_ff;
  logic tick_200ms;
  logic tick_1s;
  logic [2:0] pin_sync_ff;
  logic pin_level_ff;
  logic event_pulse;
  mode_t mode_ff;
  item_t item_ff;
  logic [31:0] thresh_ff;
  logic [15:0] period_ff;
  run_state_t state_ff;
  logic [31:0] events_ff;
  logic [15:0] seconds_ff;
  logic [31:0] shown_events_ff;
  logic [15:0] shown_seconds_ff;
  logic trig_ff;
  logic stop_now;
  logic start_now;

  // one 200 ms divider; the second tick is every fifth, so they align
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      div_ff <= 32'h0000_0000;
      sub_ff <= 3'h0;
    end else if (state_ff == ST_IDLE) begin
      div_ff <= 32'h0000_0000; // R15
      sub_ff <= 3'h0;
    end else if (tick_200ms) begin
      div_ff <= 32'h0000_0000;
      sub_ff <= (sub_ff == `TICKS_200MS_PER_S - 3'h1) ? 3'h0 : sub_ff + 3'h1;
    end else begin
      div_ff <= div_ff + 32'h0000_0001;
    end
  end

  assign tick_200ms = (div_ff == CYC_200MS - 32'h0000_0001); // R15
  assign tick_1s = tick_200ms && (sub_ff == `TICKS_200MS_PER_S - 3'h1);

  // ----------------------------------------------------------
  // event pin: three flops, change counts when stages two and three agree
  // ----------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pin_sync_ff <= 3'b000;
      pin_level_ff <= 1'b0;
    end else begin
      pin_sync_ff <= {pin_sync_ff[1:0], event_input_pin};
      if (pin_sync_ff[1] == pin_sync_ff[2])
        pin_level_ff <= pin_sync_ff[2];
    end
  end

  // only a low-to-high change of the filtered level is an event
  assign event_pulse = (pin_sync_ff[1] == pin_sync_ff[2]) &&
                       pin_sync_ff[2] && !pin_level_ff; // R01

  // ----------------------------------------------------------
  // settings menu
  // ----------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n)
      item_ff <= ITEM_MODE;
    else if (sel_next)
      item_ff <= item_t'(item_ff + 2'b01); // R14
  end

  // mode change is refused while counting to keep results coherent
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mode_ff <= MODE_FREE;
    end else if (item_ff == ITEM_MODE && state_ff == ST_IDLE) begin
      case (mode_ff)
        MODE_FREE: begin
          if (inc) mode_ff <= MODE_TIMED; // R14
          else if (dec) mode_ff <= MODE_EVENTS;
        end
        MODE_TIMED: begin
          if (inc) mode_ff <= MODE_EVENTS;
          else if (dec) mode_ff <= MODE_FREE;
        end
        MODE_EVENTS: begin
          if (inc) mode_ff <= MODE_FREE;
          else if (dec) mode_ff <= MODE_TIMED;
        end
        default: mode_ff <= MODE_FREE;
      endcase
    end
  end

  // threshold, saturating between 1 and the event limit
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      thresh_ff <= `THRESH_DEFAULT; // R05
    end else if (item_ff == ITEM_THRESH && mode_ff == MODE_EVENTS) begin
      if (set_default)
        thresh_ff <= `THRESH_DEFAULT; // R05 R06
      else if (inc && thresh_ff < `EVENT_LIMIT)
        thresh_ff <= thresh_ff + 32'h0000_0001; // R06
      else if (dec && thresh_ff > 32'h0000_0001)
        thresh_ff <= thresh_ff - 32'h0000_0001;
    end
  end

  // period in seconds, kept between 1 and the time limit
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      period_ff <= `PERIOD_DEFAULT; // R07
    end else if (item_ff == ITEM_PERIOD && mode_ff == MODE_TIMED) begin
      if (set_default)
        period_ff <= `PERIOD_DEFAULT; // R07
      else if (inc && period_ff < `TIME_LIMIT)
        period_ff <= period_ff + 16'h0001; // R07
      else if (dec && period_ff > 16'h0001)
        period_ff <= period_ff - 16'h0001;
    end
  end

  // ----------------------------------------------------------
  // run control
  // ----------------------------------------------------------
  assign start_now = start_stop && item_ff == ITEM_RUN && state_ff == ST_IDLE;

  // time stops are exact on the second; event checks only at 200 ms
  always_comb begin
    stop_now = 1'b0;
    if (state_ff == ST_RUN) begin
      if (start_stop && item_ff == ITEM_RUN)
        stop_now = 1'b1; // R08
      if (tick_1s && seconds_ff + 16'h0001 >= `TIME_LIMIT)
        stop_now = 1'b1; // R10 R11
      if (tick_1s && mode_ff == MODE_TIMED &&
          seconds_ff + 16'h0001 >= period_ff)
        stop_now = 1'b1; // R03
      if (tick_200ms && events_ff > `EVENT_LIMIT)
        stop_now = 1'b1; // R10 R11 R12
      if (tick_200ms && mode_ff == MODE_EVENTS && events_ff >= thresh_ff)
        stop_now = 1'b1; // R04 R12
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n)
      state_ff <= ST_IDLE;
    else if (start_now)
      state_ff <= ST_RUN; // R08
    else if (stop_now)
      state_ff <= ST_IDLE; // R02 R11
  end

  // working counters, cleared on each start
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      events_ff <= 32'h0000_0000; // R15
      seconds_ff <= 16'h0000;
    end else if (start_now) begin
      events_ff <= 32'h0000_0000; // R08
      seconds_ff <= 16'h0000;
    end else if (state_ff == ST_RUN) begin
      if (event_pulse && events_ff != 32'hFFFF_FFFF)
        events_ff <= events_ff + 32'h0000_0001; // R01 R02
      if (tick_1s)
        seconds_ff <= seconds_ff + 16'h0001; // R02
    end
  end

  // published values: each second, at start and at stop; held when idle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      shown_events_ff <= 32'h0000_0000;
      shown_seconds_ff <= 16'h0000;
    end else if (start_now) begin
      shown_events_ff <= 32'h0000_0000;
      shown_seconds_ff <= 16'h0000;
    end else if (stop_now || tick_1s) begin
      shown_events_ff <= events_ff + ((event_pulse &&
        events_ff != 32'hFFFF_FFFF) ? 32'h0000_0001 : 32'h0000_0000); // R09
      shown_seconds_ff <= seconds_ff + (tick_1s ? 16'h0001 : 16'h0000);
    end
  end

  // trigger follows the run state when enabled
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n)
      trig_ff <= 1'b0;
    else
      trig_ff <= trig_enable && (start_now ||
                 (state_ff == ST_RUN && !stop_now)); // R13
  end

  assign mode = mode_ff;
  assign item = item_ff;
  assign threshold = thresh_ff;
  assign period = period_ff;
  assign running = (state_ff == ST_RUN);
  assign shown_events = shown_events_ff;
  assign shown_seconds = shown_seconds_ff;
  assign trigger_out = trig_ff;
endmodule

// File: dv/event_counter_properties.sv
// port checker for the event counter
`timescale 1ns/10ps
module event_counter_props (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic sel_next,
  input wire logic set_default,
  input wire logic start_stop,
  input wire logic trig_enable,
  input wire evcnt_pkg::mode_t mode,
  input wire evcnt_pkg::item_t item,
  input wire logic [31:0] threshold,
  input wire logic [15:0] period,
  input wire logic running,
  input wire logic [31:0] shown_events,
  input wire logic [15:0] shown_seconds,
  input wire logic trigger_out
);
  import evcnt_pkg::*;
  // ----
  // one clock domain, so one default clocking
  // ----
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence s_go;
    start_stop && item == ITEM_RUN;
  endsequence
  property p_run_on; s_go ##0 !running |=> running; endproperty
  property p_run_off; s_go ##0 running |=> !running; endproperty
  property p_ss_off;
    start_stop && item != ITEM_RUN && !running |=> !running;
  endproperty
  // trigger flop loads the next run state, so it moves with running
  property p_trig; trigger_out == ($past(trig_enable) && running); endproperty
  property p_clr; $rose(running) |-> !shown_events && !shown_seconds;
  endproperty
  property p_thr; mode != MODE_EVENTS |=> $stable(threshold); endproperty
  property p_per; mode != MODE_TIMED |=> $stable(period); endproperty
  property p_sel; sel_next |=> item == item_t'($past(item) + 2'd1);
  endproperty
  property p_mode; running |=> $stable(mode); endproperty
  property p_dflt;
    set_default && item == ITEM_THRESH && mode == MODE_EVENTS
      |=> threshold == 32'h0000_0064;
  endproperty
  a_run_on: assert property (p_run_on) else $error("no start");
  a_run_off: assert property (p_run_off) else $error("no stop");
  a_ss_off: assert property (p_ss_off) else $error("stray start");
  a_trig: assert property (p_trig) else $error("trigger wrong");
  a_clr: assert property (p_clr) else $error("shown not cleared");
  a_thr: assert property (p_thr) else $error("threshold edited");
  a_per: assert property (p_per) else $error("period edited");
  a_sel: assert property (p_sel) else $error("item step");
  a_mode: assert property (p_mode) else $error("mode moved");
  a_dflt: assert property (p_dflt) else $error("default lost");
endmodule
bind event_counter event_counter_props chk_u (.clock(clock), .rst_n(rst_n),
  .sel_next(sel_next), .set_default(set_default), .start_stop(start_stop),
  .trig_enable(trig_enable), .mode(mode), .item(item),
  .threshold(threshold), .period(period), .running(running),
  .shown_events(shown_events), .shown_seconds(shown_seconds),
  .trigger_out(trigger_out));

// File: dv/pulse_source.sv
// pulse source standing at the event input pin
`timescale 1ns/10ps
module pulse_source (
  input wire logic enable,
  input wire logic [7:0] gap,
  output logic event_input_pin
);
  // half period at least 3 clocks, else the synchroniser may miss edges
  initial begin
    event_input_pin = 1'b0;
    forever begin
      #60;
      if (enable) event_input_pin = ~event_input_pin;
      #(gap);
    end
  end
endmodule

// File: dv/tb.sv
// self-checking bench for the event counter
`timescale 1ns/10ps
`include "evcnt_map.svh"
module tb;
  import evcnt_pkg::*;
  logic clock = 1'b0, rst_n = 1'b0, sel_next = 1'b0, inc = 1'b0;
  logic dec = 1'b0, set_default = 1'b0, start_stop = 1'b0;
  logic trig_enable = 1'b0, src_en = 1'b0, event_input_pin;
  logic [7:0] gap = 8'h00;
  mode_t mode;
  item_t item;
  logic [31:0] threshold, shown_events, seed = 32'h1c7e_a46c;
  logic [15:0] period, shown_seconds;
  logic running, trigger_out;
  int bad_count = 0, tests_run = 0, cycles = 0, k;
  int pin_rises = 0;
  always #10 clock = ~clock;
  // every rising edge the source makes is one event to expect
  always @(posedge event_input_pin) pin_rises++;
  event_counter dut_u (.clock(clock), .rst_n(rst_n),
    .event_input_pin(event_input_pin), .sel_next(sel_next), .inc(inc),
    .dec(dec), .set_default(set_default), .start_stop(start_stop),
    .trig_enable(trig_enable), .mode(mode), .item(item),
    .threshold(threshold), .period(period), .running(running),
    .shown_events(shown_events), .shown_seconds(shown_seconds),
    .trigger_out(trigger_out));
  pulse_source src_u (.enable(src_en), .gap(gap),
    .event_input_pin(event_input_pin));
  // ----
  // helpers
  // ----
  function automatic logic [31:0] rnd(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic item_t step(input item_t i);
    return item_t'(i + 2'd1);
  endfunction
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one-cycle pulse: 0 select, 1 inc, 2 dec, 3 default, 4 start/stop
  task automatic hit(int which);
    @(posedge clock);
    #1 {sel_next, inc, dec, set_default, start_stop} = 5'h10 >> which;
    @(posedge clock);
    #1 {sel_next, inc, dec, set_default, start_stop} = 5'h00;
  endtask
  task automatic go(item_t to);
    item_t e;
    for (int n = 0; n < 4 && item !== to; n++) begin
      e = step(item);
      hit(0);
      chk("item", 32'(e), 32'(item));
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // hang guard, far above the few hundred cycles the run needs
  always @(posedge clock) begin
    cycles++;
    if (cycles == 4000) begin
      bad_count++;
      complete_run;
    end
  end
  initial begin
    repeat (5) @(posedge clock);
    #1 rst_n = 1'b1;
    chk("thr", `THRESH_DEFAULT, threshold);
    chk("per", 32'(`PERIOD_DEFAULT), 32'(period));
    chk("mode", 32'(MODE_FREE), 32'(mode));
    // free mode leaves both settings locked
    go(ITEM_THRESH);
    hit(1);
    chk("thr lock", `THRESH_DEFAULT, threshold);
    go(ITEM_PERIOD);
    hit(1);
    chk("per lock", 32'(`PERIOD_DEFAULT), 32'(period));
    go(ITEM_MODE);
    hit(1);
    chk("mode", 32'(MODE_TIMED), 32'(mode));
    seed = rnd(seed);
    k = 1 + seed[2:0];
    go(ITEM_PERIOD);
    repeat (k) hit(1);
    chk("per inc", 32'(`PERIOD_DEFAULT) + k, 32'(period));
    hit(2);
    chk("per dec", 32'(`PERIOD_DEFAULT) + k - 1, 32'(period));
    hit(3);
    chk("per dflt", 32'(`PERIOD_DEFAULT), 32'(period));
    go(ITEM_MODE);
    hit(1);
    chk("mode", 32'(MODE_EVENTS), 32'(mode));
    hit(2);
    chk("mode dec", 32'(MODE_TIMED), 32'(mode));
    hit(1);
    chk("mode inc", 32'(MODE_EVENTS), 32'(mode));
    go(ITEM_THRESH);
    repeat (k) hit(2);
    chk("thr dec", `THRESH_DEFAULT - k, threshold);
    hit(1);
    chk("thr inc", `THRESH_DEFAULT - k + 1, threshold);
    hit(3);
    chk("thr dflt", `THRESH_DEFAULT, threshold);
    hit(4);
    chk("stray run", 1'b0, running);
    // run with random pin rate; mode must hold while counting
    trig_enable = 1'b1;
    gap = seed[15:8];
    go(ITEM_RUN);
    hit(4);
    chk("run", 1'b1, running);
    chk("trig up", 1'b1, trigger_out);
    @(posedge clock);
    #1 chk("trig", 1'b1, trigger_out);
    // pin only starts toggling once counting runs, so every rise counts
    src_en = 1'b1;
    go(ITEM_MODE);
    hit(1);
    chk("mode run", 32'(MODE_EVENTS), 32'(mode));
    go(ITEM_RUN);
    repeat (200) @(posedge clock);
    // quiet pin and let the synchroniser drain before stopping
    #1 src_en = 1'b0;
    repeat (10) @(posedge clock);
    hit(4);
    chk("stop", 1'b0, running);
    chk("events", pin_rises, shown_events);
    chk("seconds", 32'h0000_0000, 32'(shown_seconds));
    @(posedge clock);
    #1 chk("trig off", 1'b0, trigger_out);
    chk("events held", pin_rises, shown_events);
    // second run with trigger disabled, cut short by a reset
    trig_enable = 1'b0;
    hit(4);
    chk("run2", 1'b1, running);
    chk("shown clr", 32'h0000_0000, shown_events);
    @(posedge clock);
    #1 chk("trig dis", 1'b0, trigger_out);
    rst_n = 1'b0;
    @(posedge clock);
    #1 chk("rst run", 1'b0, running);
    chk("rst shown", 32'h0000_0000, shown_events);
    chk("rst thr", `THRESH_DEFAULT, threshold);
    rst_n = 1'b1;
    go(ITEM_THRESH);
    chk("rst mode", 32'(MODE_FREE), 32'(mode));
    complete_run;
  end
endmodule
